//--- verilog/rst_src_pkg.sv
package rst_src_pkg;

  // ------------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;      // 20 MHz system clock
  localparam int POR_DELAY_NS    = 300000;  // power-on delay, 0.3 ms
  localparam int POR_DELAY_CYC   = POR_DELAY_NS / CLK_PERIOD_NS;  // longest, rounds down
  localparam int MCD_TIMEOUT_NS  = 100000;  // missing clock time-out
  localparam int MCD_TIMEOUT_CYC = MCD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int HOLD_MIN_CYC    = 16;      // least core reset width, event causes
  localparam int CNT_W           = 16;      // width of the delay counters

  // ------------------------------------------------------------------
  // register map (printed offsets are indices, byte address = 4 * index)
  // ------------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [7:0]  IDX_MON_CTRL     = 8'hff;
  localparam logic [7:0]  IDX_CAUSE        = 8'hef;
  localparam logic [11:0] ADDR_MON_CTRL    = {2'h0, IDX_MON_CTRL, 2'h0};
  localparam logic [11:0] ADDR_CAUSE       = {2'h0, IDX_CAUSE, 2'h0};

  // supply_monitor_control fields
  localparam int          MON_EN_BIT       = 7;
  localparam int          MON_STAT_BIT     = 6;

  // reset_cause_register fields
  localparam int          PIN_FLAG_BIT     = 0;
  localparam int          POR_FLAG_BIT     = 1;
  localparam int          MCD_FLAG_BIT     = 2;
  localparam int          SW_FLAG_BIT      = 4;
  localparam int          CMP_FLAG_BIT     = 5;

  // reset values
  localparam logic [15:0] BOOT_ADDR        = 16'h0000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POR_WAIT  = 2'b00,
    ST_POR_DELAY = 2'b01,
    ST_RUN       = 2'b11,
    ST_HOLD      = 2'b10
  } seq_e;

  typedef enum logic [2:0] {
    CAUSE_NONE   = 3'h0,
    CAUSE_SUPPLY = 3'h1,
    CAUSE_PIN    = 3'h2,
    CAUSE_MCD    = 3'h3,
    CAUSE_CMP    = 3'h4,
    CAUSE_SW     = 3'h5
  } cause_e;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic pin_o;
    logic pin_oe;
  } pin_drv_s;

endpackage

//--- verilog/reset_source_controller.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module reset_source_controller
  import rst_src_pkg::*;
#(
  parameter int POR_CYC     = rst_src_pkg::POR_DELAY_CYC,
  parameter int MCD_CYC     = rst_src_pkg::MCD_TIMEOUT_CYC,
  parameter int HOLD_CYC    = rst_src_pkg::HOLD_MIN_CYC
) (
  // clock and power-on reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // apb slave
  input  wire rst_src_pkg::apb_req_s apb_req,
  output rst_src_pkg::apb_rsp_s      apb_rsp,
  // analogue levels and pins, asynchronous
  input  wire logic                  supply_above_threshold,
  input  wire logic                  comparator_out,
  input  wire logic                  rst_pin_i,
  input  wire logic                  sys_clk_in,
  // reset pin drive
  output rst_src_pkg::pin_drv_s      rst_pin,
  // core side
  output logic                       sys_rst_n,
  output logic [15:0]                boot_address
);
  import rst_src_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef struct packed {
    seq_e             seq;
    cause_e           cause;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] mcd_cnt;
    logic [2:0]       pin_s;
    logic [2:0]       sup_s;
    logic [2:0]       cmp_s;
    logic [2:0]       sck_s;
    logic [2:0]       oe_s;
    logic             mon_en;
    logic             mon_sel;
    logic             cmp_sel;
    logic             mcd_en;
    logic             sw_req;
    logic             f_pin;
    logic             f_por;
    logic             f_mcd;
    logic             f_sw;
    logic             f_cmp;
    logic             core_rst_n;
    pin_drv_s         drv;
    apb_rsp_s         rsp;
    logic [15:0]      boot;
  } state_s;

  state_s st_q;
  state_s st_d;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // shift a pin into a synchroniser; only bits [2:1] are ever read
  function automatic logic [2:0] sync_in(input logic [2:0] s, input logic d);
    sync_in = {s[1:0], d};
  endfunction

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] c);
    sat_inc = (c == {CNT_W{1'b1}}) ? c : c + 1'b1;
  endfunction

  // synchronised levels (second stage and later only)
  logic sup_ok;
  logic pin_low;
  logic cmp_low;
  logic sck_edge;
  logic supply_fail;
  logic mcd_timeout;
  logic setup;
  logic wr_take;
  logic [ADDR_W-1:0] a;

  assign sup_ok      = st_q.sup_s[1];
  // own drive ignored, and for three edges after it ends: the pin level
  // takes that long to come back through the synchroniser, and a stale
  // low there would otherwise look like an external reset
  assign pin_low     = ~st_q.pin_s[1] & ~st_q.drv.pin_oe & ~(|st_q.oe_s);
  assign cmp_low     = ~st_q.cmp_s[1];                         // plus below minus
  assign sck_edge    = st_q.sck_s[2] ^ st_q.sck_s[1];
  assign supply_fail = st_q.mon_en & st_q.mon_sel & ~sup_ok;
  assign mcd_timeout = st_q.mcd_en & (st_q.mcd_cnt >= CNT_W'(MCD_CYC));
  assign setup       = apb_req.psel & ~apb_req.penable;
  assign wr_take     = apb_req.psel & apb_req.penable & apb_req.pwrite & st_q.rsp.pready;
  assign a           = apb_req.paddr;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // synchronisers on every asynchronous level
    st_d.sup_s = sync_in(st_q.sup_s, supply_above_threshold);
    st_d.pin_s = sync_in(st_q.pin_s, rst_pin_i);
    st_d.cmp_s = sync_in(st_q.cmp_s, comparator_out);
    st_d.sck_s = sync_in(st_q.sck_s, sys_clk_in);
    // history of our own pin drive, masks the synchroniser latency
    st_d.oe_s  = {st_q.oe_s[1:0], st_q.drv.pin_oe};

    // missing clock one-shot, retriggered by every system clock edge
    if (!st_q.mcd_en || sck_edge) begin
      st_d.mcd_cnt = '0;
    end else begin
      st_d.mcd_cnt = sat_inc(st_q.mcd_cnt);
    end

    st_d.boot = BOOT_ADDR;

    // apb answer prepared in setup, shown throughout the access phase
    st_d.rsp.pready  = setup;
    st_d.rsp.pslverr = 1'b0;
    st_d.rsp.prdata  = '0;
    if (setup) begin
      if (a == ADDR_MON_CTRL) begin
        st_d.rsp.prdata[MON_EN_BIT]   = st_q.mon_en;
        st_d.rsp.prdata[MON_STAT_BIT] = sup_ok;
      end else if (a == ADDR_CAUSE) begin
        st_d.rsp.prdata[PIN_FLAG_BIT] = st_q.f_pin;
        st_d.rsp.prdata[POR_FLAG_BIT] = st_q.f_por;
        st_d.rsp.prdata[MCD_FLAG_BIT] = st_q.f_mcd;
        st_d.rsp.prdata[SW_FLAG_BIT]  = st_q.f_sw;
        st_d.rsp.prdata[CMP_FLAG_BIT] = st_q.f_cmp;
      end else begin
        st_d.rsp.pslverr = 1'b1;                               // unmapped word
      end
    end else if (st_q.rsp.pready && !(apb_req.psel && apb_req.penable)) begin
      st_d.rsp.pready = 1'b0;                                  // master withdrew
    end

    // register writes, taken at the completing access edge
    if (wr_take) begin
      if (a == ADDR_MON_CTRL) begin
        st_d.mon_en = apb_req.pwdata[MON_EN_BIT];
      end else if (a == ADDR_CAUSE) begin
        // written bits 1, 2, 4 and 5 act directly, so rewriting a read value
        // can arm a source or fire a reset
        st_d.mon_sel = apb_req.pwdata[POR_FLAG_BIT];
        st_d.mcd_en  = apb_req.pwdata[MCD_FLAG_BIT];
        st_d.cmp_sel = apb_req.pwdata[CMP_FLAG_BIT];
        st_d.sw_req  = apb_req.pwdata[SW_FLAG_BIT];
      end
    end

    // reset sequencer
    unique case (st_q.seq)
      ST_POR_WAIT: begin
        st_d.core_rst_n = 1'b0;
        st_d.drv.pin_oe = 1'b1;
        st_d.cnt        = '0;
        if (sup_ok) begin
          st_d.seq = ST_POR_DELAY;
        end
      end

      ST_POR_DELAY: begin
        st_d.drv.pin_oe = 1'b1;
        st_d.cnt        = sat_inc(st_q.cnt);
        if (!sup_ok) begin
          st_d.seq = ST_POR_WAIT;
        end else if (st_q.cnt >= CNT_W'(POR_CYC - 1)) begin
          st_d.seq        = ST_RUN;
          st_d.core_rst_n = 1'b1;
          st_d.drv.pin_oe = 1'b0;
          st_d.f_por      = 1'b1;
          st_d.f_pin      = 1'b0;
          st_d.f_mcd      = 1'b0;
          st_d.f_sw       = 1'b0;
          st_d.f_cmp      = 1'b0;
        end
      end

      ST_RUN: begin
        st_d.cnt = '0;
        // priority: supply, pin, clock loss, comparator, software
        if (supply_fail) begin
          st_d.cause      = CAUSE_SUPPLY;
          st_d.drv.pin_oe = 1'b1;
        end else if (pin_low) begin
          st_d.cause = CAUSE_PIN;
        end else if (mcd_timeout) begin
          st_d.cause = CAUSE_MCD;
        end else if (st_q.cmp_sel && cmp_low) begin
          st_d.cause = CAUSE_CMP;
        end else if (st_q.sw_req) begin
          st_d.cause = CAUSE_SW;
        end else begin
          st_d.cause = CAUSE_NONE;
        end
        if (st_d.cause != CAUSE_NONE) begin
          st_d.seq        = ST_HOLD;
          st_d.core_rst_n = 1'b0;
          // control bits of the cause register fall back to off;
          // monitor enable and selection are kept
          st_d.mcd_en     = 1'b0;
          st_d.cmp_sel    = 1'b0;
          st_d.sw_req     = 1'b0;
          st_d.mcd_cnt    = '0;
        end
      end

      ST_HOLD: begin
        st_d.cnt    = sat_inc(st_q.cnt);
        st_d.sw_req = 1'b0;
        // a supply drop overrides any milder cause in progress
        if (supply_fail) begin
          st_d.cause      = CAUSE_SUPPLY;
          st_d.drv.pin_oe = 1'b1;
        end
        if (st_q.cause == CAUSE_SUPPLY) begin
          // release as soon as supply is back, no power-on delay
          if (sup_ok) begin
            st_d.seq        = ST_RUN;
            st_d.core_rst_n = 1'b1;
            st_d.drv.pin_oe = 1'b0;
            st_d.f_por      = 1'b1;
            st_d.f_pin      = 1'b0;
            st_d.f_mcd      = 1'b0;
            st_d.f_sw       = 1'b0;
            st_d.f_cmp      = 1'b0;
          end
        end else if (!supply_fail && st_q.cnt >= CNT_W'(HOLD_CYC - 1)
                     && !(st_q.cause == CAUSE_PIN && ~st_q.pin_s[1])
                     && !(st_q.cause == CAUSE_CMP && cmp_low)) begin
          st_d.seq        = ST_RUN;
          st_d.core_rst_n = 1'b1;
          st_d.f_por      = 1'b0;
          st_d.f_pin      = (st_q.cause == CAUSE_PIN);
          st_d.f_mcd      = (st_q.cause == CAUSE_MCD);
          st_d.f_sw       = (st_q.cause == CAUSE_SW);
          st_d.f_cmp      = (st_q.cause == CAUSE_CMP);
        end
      end
    endcase
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // power-on reset: core held, pin driven, monitor on and selected
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q            <= '0;
      st_q.seq        <= ST_POR_WAIT;
      st_q.cause      <= CAUSE_NONE;
      st_q.mon_en     <= 1'b1;
      st_q.mon_sel    <= 1'b1;
      st_q.drv.pin_oe <= 1'b1;
      st_q.oe_s       <= 3'h7;
      st_q.boot       <= BOOT_ADDR;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ------------------------------------------------------------------
  assign apb_rsp      = st_q.rsp;
  assign rst_pin      = st_q.drv;
  assign sys_rst_n    = st_q.core_rst_n;
  assign boot_address = st_q.boot;

endmodule

//--- verification/reset_source_checker.sv
`timescale 1ns/1ps
module reset_source_checker #(
  parameter int POR_CYC = 20
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  rstn,
  // register bus
  input wire rst_src_pkg::apb_req_s apb_req,
  input wire rst_src_pkg::apb_rsp_s apb_rsp,
  // asynchronous levels
  input wire logic                  supply_above_threshold,
  input wire logic                  comparator_out,
  input wire logic                  rst_pin_i,
  input wire logic                  sys_clk_in,
  // pin and core side
  input wire rst_src_pkg::pin_drv_s rst_pin,
  input wire logic                  sys_rst_n,
  input wire logic [15:0]           boot_address
);
  import rst_src_pkg::*;
  logic [3:0]  hi_q;
  logic [15:0] age_q;
  logic        rd_ctrl;
  logic        unmapped;

  // supply-high run length and age since reset, both saturate
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hi_q  <= 4'h0;
      age_q <= 16'h0000;
    end else begin
      hi_q  <= !supply_above_threshold ? 4'h0 : (hi_q == 4'h8 ? hi_q : hi_q + 4'h1);
      age_q <= (&age_q) ? age_q : age_q + 16'h0001;
    end
  end

  // access-phase decodes, address is still held there
  assign rd_ctrl  = apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == ADDR_MON_CTRL;
  assign unmapped = apb_req.paddr != ADDR_MON_CTRL && apb_req.paddr != ADDR_CAUSE;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  a_boot_fixed: assert property (boot_address == 16'h0000)
    else $error("boot address not zero");
  a_pin_low_held: assert property (rst_pin.pin_oe |-> !rst_pin.pin_o && !sys_rst_n)
    else $error("pin driven while core runs or pin high");
  a_ready_next: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_single: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready stands too long");
  a_ctrl_zeros: assert property (rd_ctrl |-> apb_rsp.prdata[5:0] == 6'h00 && apb_rsp.prdata[31:8] == 24'h0)
    else $error("monitor control unused bits not zero");
  a_status_live: assert property (rd_ctrl && hi_q == 4'h8 |-> apb_rsp.prdata[6])
    else $error("supply status not shown");
  a_unmapped_err: assert property (apb_rsp.pready && unmapped |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
  a_por_delay: assert property (sys_rst_n |-> age_q >= POR_CYC)
    else $error("core released before power-on delay");
  a_event_no_pin: assert property ($fell(sys_rst_n) && hi_q == 4'h8 |-> !rst_pin.pin_oe)
    else $error("pin driven for an event reset");
endmodule

//--- verification/reset_source_partner.sv
`timescale 1ns/1ps
module reset_source_partner (
  // controls from the bench
  input  wire logic                  supply_ok,
  input  wire logic                  cmp_ok,
  input  wire logic                  ext_low,
  input  wire logic                  clk_run,
  input  wire rst_src_pkg::pin_drv_s pin_drv,
  // levels seen by the block
  output logic                       supply_above_threshold,
  output logic                       comparator_out,
  output logic                       rst_pin_i,
  output logic                       sys_clk_in
);
  import rst_src_pkg::*;

  // analogue comparisons reduced to levels
  assign supply_above_threshold = supply_ok;
  assign comparator_out         = cmp_ok;
  // pulled-up pin, low when either party pulls it
  assign rst_pin_i = !(ext_low || (pin_drv.pin_oe && !pin_drv.pin_o));

  // watched clock stands still when stopped, so a stall is real
  initial begin
    sys_clk_in = 1'b0;
    forever #60 if (clk_run) sys_clk_in = !sys_clk_in;
  end
endmodule

//--- verification/test_reset_source_controller.sv
`timescale 1ns/1ps
module test_reset_source_controller;
  import rst_src_pkg::*;
  localparam int POR_T = 20;
  logic        clk, rstn, supply_ok, cmp_ok, ext_low, clk_run;
  logic        sup, cmp, pin_i, sclk, sys_rst_n;
  logic [15:0] boot;
  apb_req_s    req;
  apb_rsp_s    rsp;
  pin_drv_s    pin;
  int          num_errors = 0;
  int          n_tests = 0;

  reset_source_controller #(.POR_CYC(POR_T), .MCD_CYC(30), .HOLD_CYC(16)) dut (
    .clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .supply_above_threshold(sup),
    .comparator_out(cmp), .rst_pin_i(pin_i), .sys_clk_in(sclk), .rst_pin(pin),
    .sys_rst_n(sys_rst_n), .boot_address(boot));
  reset_source_partner far (
    .supply_ok(supply_ok), .cmp_ok(cmp_ok), .ext_low(ext_low), .clk_run(clk_run),
    .pin_drv(pin), .supply_above_threshold(sup), .comparator_out(cmp),
    .rst_pin_i(pin_i), .sys_clk_in(sclk));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict();
    $display("TB: %0d checks, %0d errors", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge clk);
    req.penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 50) begin
      num_errors++;
      give_verdict();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(nm, exp, r);
  endtask
  // bounded wait for the core reset to reach a level
  task automatic wait_rst(input logic lvl, output int n);
    for (n = 0; n < 3000; n++) begin
      @(posedge clk);
      if (sys_rst_n === lvl) break;
    end
    if (n == 3000) begin
      num_errors++;
      give_verdict();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    int          n;
    logic [31:0] r;
    logic        e;
    rstn = 1'b0;
    req = '0;
    supply_ok = 1'b1;
    cmp_ok = 1'b1;
    ext_low = 1'b0;
    clk_run = 1'b1;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    check("por core", 32'h0, {31'h0, sys_rst_n});
    check("por pin", 32'h1, {31'h0, pin.pin_oe});
    wait_rst(1'b1, n);
    check("por delay", 32'h1, {31'h0, n >= POR_T});
    check("boot", 32'h0, {16'h0, boot});
    rd("cause por", ADDR_CAUSE, 32'h02);
    rd("ctrl por", ADDR_MON_CTRL, 32'hc0);
    $display("TB: test power_on done");
    wr(ADDR_MON_CTRL, 32'h3f);
    rd("ctrl off", ADDR_MON_CTRL, 32'h40);
    wr(ADDR_MON_CTRL, 32'h80);
    rd("ctrl on", ADDR_MON_CTRL, 32'hc0);
    $display("TB: test control done");
    wr(ADDR_CAUSE, 32'h02);
    supply_ok <= 1'b0;
    wait_rst(1'b0, n);
    @(posedge clk);
    check("drop pin", 32'h1, {31'h0, pin.pin_oe});
    rd("ctrl low", ADDR_MON_CTRL, 32'h80);
    supply_ok <= 1'b1;
    wait_rst(1'b1, n);
    check("no delay", 32'h1, {31'h0, n < POR_T});
    rd("cause drop", ADDR_CAUSE, 32'h02);
    $display("TB: test supply done");
    ext_low <= 1'b1;
    wait_rst(1'b0, n);
    ext_low <= 1'b0;
    wait_rst(1'b1, n);
    rd("cause pin", ADDR_CAUSE, 32'h01);
    rd("ctrl kept", ADDR_MON_CTRL, 32'hc0);
    $display("TB: test pin done");
    wr(ADDR_CAUSE, 32'h06);
    repeat (60) @(posedge clk);
    check("clock ok", 32'h1, {31'h0, sys_rst_n});
    clk_run <= 1'b0;
    wait_rst(1'b0, n);
    check("mcd pin", 32'h0, {31'h0, pin.pin_oe});
    clk_run <= 1'b1;
    wait_rst(1'b1, n);
    rd("cause mcd", ADDR_CAUSE, 32'h04);
    $display("TB: test clock_loss done");
    cmp_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check("cmp unsel", 32'h1, {31'h0, sys_rst_n});
    wr(ADDR_CAUSE, 32'h22);
    wait_rst(1'b0, n);
    check("cmp pin", 32'h0, {31'h0, pin.pin_oe});
    cmp_ok <= 1'b1;
    wait_rst(1'b1, n);
    rd("cause cmp", ADDR_CAUSE, 32'h20);
    $display("TB: test comparator done");
    wr(ADDR_MON_CTRL, 32'h00);
    wr(ADDR_CAUSE, 32'h12);
    wait_rst(1'b0, n);
    check("sw pin", 32'h0, {31'h0, pin.pin_oe});
    wait_rst(1'b1, n);
    rd("cause sw", ADDR_CAUSE, 32'h10);
    rd("ctrl off kept", ADDR_MON_CTRL, 32'h40);
    supply_ok <= 1'b0;
    repeat (20) @(posedge clk);
    check("mon off", 32'h1, {31'h0, sys_rst_n});
    rd("ctrl off low", ADDR_MON_CTRL, 32'h00);
    supply_ok <= 1'b1;
    apb(1'b0, 12'h100, 32'h0, r, e);
    check("unmapped err", 32'h1, {31'h0, e});
    check("unmapped data", 32'h0, r);
    $display("TB: test software done");
    give_verdict();
  end
endmodule

bind reset_source_controller reset_source_checker #(.POR_CYC(POR_CYC)) chk (
  .clk(clk), .rstn(rstn), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .supply_above_threshold(supply_above_threshold), .comparator_out(comparator_out),
  .rst_pin_i(rst_pin_i), .sys_clk_in(sys_clk_in), .rst_pin(rst_pin),
  .sys_rst_n(sys_rst_n), .boot_address(boot_address));
